// file: battery_alarm_pkg.sv
/*
 Constants for the battery alarm and mode-flag block: register offsets,
 field positions and reset values. Assumes a 32-bit APB slave, byte addresses.
*/
`default_nettype none
package battery_alarm_pkg;
   localparam int ADDR_W = 8;
   // register byte offsets
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_LOWCAP_THR = 8'h04;
   localparam logic [7:0] OFF_SHUT_SET = 8'h08;
   localparam logic [7:0] OFF_SHUT_CLR = 8'h0C;
   localparam logic [7:0] OFF_FINAL_V = 8'h10;
   localparam logic [7:0] OFF_CC_GAIN = 8'h14;
   localparam logic [7:0] OFF_CC_DELTA = 8'h18;
   localparam logic [7:0] OFF_FLAGS = 8'h1C;
   localparam logic [7:0] OFF_CTRL_STAT = 8'h20;
   localparam logic [7:0] OFF_SOC = 8'h24;
   localparam logic [7:0] OFF_INT_STAT = 8'h28;
   localparam logic [7:0] OFF_INT_CLR = 8'h2C;
   localparam logic [7:0] OFF_INT_EN = 8'h30;
   localparam logic [7:0] OFF_CHARGE = 8'h34;
   // field positions
   localparam int CTRL_MODEL_BIT = 0;
   localparam int CTRL_PIN_EN_BIT = 1;
   localparam int FLAG_LOWCAP_BIT = 0;
   localparam int FLAG_SHUT_BIT = 1;
   localparam int STAT_MODEL_BIT = 0;
   localparam int EV_LOWCAP_SET = 0;
   localparam int EV_SHUT_SET = 1;
   localparam int EV_SHUT_CLR = 2;
   localparam int NUM_EV = 3;
   // values after reset
   localparam logic [1:0] RST_CTRL = 2'h0;
   localparam logic [15:0] RST_LOWCAP_THR = 16'h0000;
   localparam logic [15:0] RST_SHUT_SET = 16'h0000;
   localparam logic [15:0] RST_SHUT_CLR = 16'h0000;
   localparam logic [15:0] RST_FINAL_V = 16'h0000;
   localparam logic [31:0] RST_CC_WORD = 32'h0000_0000;
endpackage
`default_nettype wire

// file: battery_alarm_flag_logic.sv
/*
 Alarm and mode-flag logic of the fuel gauge: low-capacity and shutdown
 flags with hysteresis, battery-low pin, state-of-charge event pulse,
 final-voltage zeroing, charge accumulation, APB register file, interrupt.
 Assumes capacity, voltage and current samples come from the measurement
 path on mclk, so they are used without synchronisers.
*/
// Implementation choices: the APB slave port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// - the low-capacity flag sets when remaining capacity falls below its threshold.
// - the low-capacity flag clears when remaining capacity rises above that threshold.
// - the battery-low pin follows the low-capacity flag.
// - the battery-low pin indicates only while its enable bit is set.
// - voltage below the shutdown set level sets the shutdown flag and pulses the SOC event.
// - the shutdown flag clears only when set and voltage rises above the clear level.
// - clearing the shutdown flag also pulses the SOC event.
// - state of charge reads zero once voltage has fallen to the final voltage.
// - load model 0 (default) is constant current, 1 is constant power.
// - the load-model setting is visible as a read-only control status bit.
// - charge is accumulated from the sense current; state of charge passes socIn through.
// - coulomb-counter gain and delta are kept as raw four-byte words, not IEEE floats.
module battery_alarm_flag_logic
   import battery_alarm_pkg::*;
#(
   parameter int CAP_W = 16,
   parameter int SOC_W = 8
)
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [CAP_W-1:0] remainingCap,
   input wire logic [CAP_W-1:0] cellVoltage,
   input wire logic [SOC_W-1:0] socIn,
   input wire logic signed [15:0] senseCurrent,
   input wire logic senseValid,
   output logic battery_low_pin,
   output logic socIntPulse,
   output logic load_model_bit,
   output logic [SOC_W-1:0] socOut,
   output logic irq
);

   typedef struct packed {
      logic [1:0] ctrl;
      logic [CAP_W-1:0] lowCapThr;
      logic [CAP_W-1:0] shutSetV;
      logic [CAP_W-1:0] shutClrV;
      logic [CAP_W-1:0] finalV;
      logic [31:0] ccGain;
      logic [31:0] ccDelta;
      logic signed [31:0] chargeAcc;
      logic evaluated;
      logic low_capacity_flag;
      logic system_shutdown_flag;
      logic socPulse;
      logic batLow;
      logic modelBit;
      logic [SOC_W-1:0] soc;
      logic [NUM_EV-1:0] intStat;
      logic [NUM_EV-1:0] intEn;
      logic irq;
      logic pready;
      logic [31:0] prdata;
      logic pslverr;
   } state_t;

   state_t st_q;
   state_t st_d;
   logic [NUM_EV-1:0] events;
   logic wrEn;
   logic rdEn;

   // one word per register, full byte-address match
   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
      hit = (a == off);
   endfunction

   function automatic logic mapped(input logic [ADDR_W-1:0] a);
      mapped = hit(a, OFF_CTRL) | hit(a, OFF_LOWCAP_THR) | hit(a, OFF_SHUT_SET)
         | hit(a, OFF_SHUT_CLR) | hit(a, OFF_FINAL_V) | hit(a, OFF_CC_GAIN)
         | hit(a, OFF_CC_DELTA) | hit(a, OFF_FLAGS) | hit(a, OFF_CTRL_STAT)
         | hit(a, OFF_SOC) | hit(a, OFF_INT_STAT) | hit(a, OFF_INT_CLR)
         | hit(a, OFF_INT_EN) | hit(a, OFF_CHARGE);
   endfunction

   // access phase takes one wait state; the transfer completes with pready
   assign wrEn = psel & penable & pwrite & st_q.pready;
   assign rdEn = psel & penable & ~pwrite & ~st_q.pready;

   // next-state logic for the whole block
   always_comb
   begin
      st_d = st_q;
      events = '0;
      st_d.pready = psel & penable & ~st_q.pready;
      st_d.pslverr = psel & penable & ~st_q.pready & ~mapped(paddr);
      // register writes land on the completing edge only
      if (wrEn)
      begin
         if (hit(paddr, OFF_CTRL))
         begin
            st_d.ctrl = pwdata[1:0];
         end
         if (hit(paddr, OFF_LOWCAP_THR))
         begin
            st_d.lowCapThr = pwdata[CAP_W-1:0];
         end
         if (hit(paddr, OFF_SHUT_SET))
         begin
            st_d.shutSetV = pwdata[CAP_W-1:0];
         end
         if (hit(paddr, OFF_SHUT_CLR))
         begin
            st_d.shutClrV = pwdata[CAP_W-1:0];
         end
         if (hit(paddr, OFF_FINAL_V))
         begin
            st_d.finalV = pwdata[CAP_W-1:0];
         end
         // stored bit for bit, no float conversion is attempted
         if (hit(paddr, OFF_CC_GAIN))
         begin
            st_d.ccGain = pwdata;
         end
         if (hit(paddr, OFF_CC_DELTA))
         begin
            st_d.ccDelta = pwdata;
         end
         if (hit(paddr, OFF_INT_EN))
         begin
            st_d.intEn = pwdata[NUM_EV-1:0];
         end
         if (hit(paddr, OFF_INT_CLR))
         begin
            st_d.intStat = st_q.intStat & ~pwdata[NUM_EV-1:0];
         end
      end
      // first cycle after reset only arms the comparators
      st_d.evaluated = 1'b1;
      st_d.socPulse = 1'b0;
      if (st_q.evaluated)
      begin
         // capacity hysteresis is the threshold itself; equal holds the flag
         if (remainingCap < st_q.lowCapThr)
         begin
            st_d.low_capacity_flag = 1'b1;
            events[EV_LOWCAP_SET] = ~st_q.low_capacity_flag;
         end
         else if (remainingCap > st_q.lowCapThr)
         begin
            st_d.low_capacity_flag = 1'b0;
         end
         // shutdown flag has separate set and clear voltages
         if (!st_q.system_shutdown_flag && cellVoltage < st_q.shutSetV)
         begin
            st_d.system_shutdown_flag = 1'b1;
            st_d.socPulse = 1'b1;
            events[EV_SHUT_SET] = 1'b1;
         end
         else if (st_q.system_shutdown_flag && cellVoltage > st_q.shutClrV)
         begin
            st_d.system_shutdown_flag = 1'b0;
            st_d.socPulse = 1'b1;
            events[EV_SHUT_CLR] = 1'b1;
         end
      end
      // pin gated by its enable, tracks the flag in the same cycle
      st_d.batLow = st_d.low_capacity_flag & st_d.ctrl[CTRL_PIN_EN_BIT];
      // 0 selects constant current, 1 constant power
      st_d.modelBit = st_d.ctrl[CTRL_MODEL_BIT];
      // coulomb counting on each valid sense sample
      if (senseValid)
      begin
         st_d.chargeAcc = st_q.chargeAcc + {{16{senseCurrent[15]}}, senseCurrent};
      end
      // reported charge forced empty at or below the final voltage
      st_d.soc = (cellVoltage <= st_q.finalV) ? '0 : socIn;
      // sticky status: a new event beats a clear in the same cycle
      st_d.intStat = st_d.intStat | events;
      st_d.irq = |(st_d.intStat & st_d.intEn);
      // read data captured one cycle before pready rises with it
      st_d.prdata = '0;
      if (rdEn)
      begin
         case (paddr)
            OFF_CTRL: st_d.prdata = 32'(st_q.ctrl);
            OFF_LOWCAP_THR: st_d.prdata = 32'(st_q.lowCapThr);
            OFF_SHUT_SET: st_d.prdata = 32'(st_q.shutSetV);
            OFF_SHUT_CLR: st_d.prdata = 32'(st_q.shutClrV);
            OFF_FINAL_V: st_d.prdata = 32'(st_q.finalV);
            OFF_CC_GAIN: st_d.prdata = st_q.ccGain;
            OFF_CC_DELTA: st_d.prdata = st_q.ccDelta;
            OFF_FLAGS:
            begin
               st_d.prdata[FLAG_LOWCAP_BIT] = st_q.low_capacity_flag;
               st_d.prdata[FLAG_SHUT_BIT] = st_q.system_shutdown_flag;
            end
            OFF_CTRL_STAT: st_d.prdata[STAT_MODEL_BIT] = st_q.modelBit;
            OFF_SOC: st_d.prdata = 32'(st_q.soc);
            OFF_INT_STAT: st_d.prdata = 32'(st_q.intStat);
            OFF_INT_EN: st_d.prdata = 32'(st_q.intEn);
            OFF_CHARGE: st_d.prdata = st_q.chargeAcc;
            default: st_d.prdata = '0; // write-only clear and holes read zero
         endcase
      end
      else if (st_q.pready)
      begin
         st_d.prdata = '0;
      end
      else
      begin
         st_d.prdata = st_q.prdata;
      end
   end

   // whole state registered here; flags cleared, no pulse during reset
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_q <= '0;
         st_q.ctrl <= RST_CTRL;
         st_q.lowCapThr <= RST_LOWCAP_THR;
         st_q.shutSetV <= RST_SHUT_SET;
         st_q.shutClrV <= RST_SHUT_CLR;
         st_q.finalV <= RST_FINAL_V;
         st_q.ccGain <= RST_CC_WORD;
         st_q.ccDelta <= RST_CC_WORD;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   assign prdata = st_q.prdata;
   assign pready = st_q.pready;
   assign pslverr = st_q.pslverr;
   assign battery_low_pin = st_q.batLow;
   assign socIntPulse = st_q.socPulse;
   assign load_model_bit = st_q.modelBit;
   assign socOut = st_q.soc;
   assign irq = st_q.irq;

   // checks on the flag, pin, pulse, state-of-charge, model-bit and charge behaviour
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   a_lowcap_set: assert property (st_q.evaluated && remainingCap < st_q.lowCapThr
      |=> st_q.low_capacity_flag) else $error("low-capacity flag not set");
   a_lowcap_clear: assert property (st_q.evaluated && remainingCap > st_q.lowCapThr
      |=> !st_q.low_capacity_flag) else $error("low-capacity flag not cleared");
   a_pin_follow: assert property (st_q.ctrl[CTRL_PIN_EN_BIT]
      |-> battery_low_pin == st_q.low_capacity_flag) else $error("pin not following");
   a_pin_gate: assert property (!st_q.ctrl[CTRL_PIN_EN_BIT] |-> !battery_low_pin)
      else $error("pin active while disabled");
   a_shut_set: assert property ($rose(st_q.system_shutdown_flag)
      |-> socIntPulse && $past(cellVoltage) < $past(st_q.shutSetV))
      else $error("bad shutdown set");
   a_shut_clear: assert property ($fell(st_q.system_shutdown_flag)
      |-> $past(cellVoltage) > $past(st_q.shutClrV)) else $error("bad shutdown clear");
   a_clear_pulse: assert property ($fell(st_q.system_shutdown_flag) |-> socIntPulse)
      else $error("no pulse on clear");
   a_soc_zero: assert property (cellVoltage <= st_q.finalV |=> socOut == '0)
      else $error("soc not zeroed");
   a_model_bit: assert property ($changed(st_q.ctrl[CTRL_MODEL_BIT])
      |=> load_model_bit == $past(st_q.ctrl[CTRL_MODEL_BIT])) else $error("model lag");
   a_charge_acc: assert property (senseValid
      |=> st_q.chargeAcc == $past(st_q.chargeAcc) + $past(32'(senseCurrent)))
      else $error("charge not accumulated");
   a_pulse_cause: assert property (socIntPulse |-> $changed(st_q.system_shutdown_flag))
      else $error("pulse without flag change");
   a_reset_quiet: assert property (!st_q.evaluated
      |-> !socIntPulse && !st_q.system_shutdown_flag) else $error("early event");

   // hysteresis hold, pass-through, pulse on every shutdown flag change and a quiet start
   // a flag that drops between the two voltages would chatter near shutdown
   a_shut_hold: assert property (st_q.evaluated && st_q.system_shutdown_flag
      && cellVoltage <= st_q.shutClrV |=> st_q.system_shutdown_flag)
      else $error("shutdown flag cleared early");
   a_soc_pass: assert property (cellVoltage > st_q.finalV |=> socOut == $past(socIn))
      else $error("soc not passed through");
   a_pulse_every: assert property ($changed(st_q.system_shutdown_flag) |-> socIntPulse)
      else $error("flag change without pulse");
   a_lowcap_quiet: assert property (!st_q.evaluated |-> !st_q.low_capacity_flag)
      else $error("early low-capacity flag");

   // covers for the main scenarios
   c_soc_zero: cover property (cellVoltage <= st_q.finalV ##1 socOut == '0);
   c_shut_set: cover property ($rose(st_q.system_shutdown_flag));
   c_shut_clear: cover property ($fell(st_q.system_shutdown_flag));
   c_pin_low: cover property ($rose(battery_low_pin));
   c_irq: cover property ($rose(irq));
endmodule
`default_nettype wire

// file: meas_model.sv
/*
 Measurement path model: capacity, voltage and current samples for the gauge.
 Assumes the bench sets targets on mclk; outputs are registered on mclk.
*/
`timescale 1ns/10ps
`default_nettype none
module meas_model
(
   input wire logic mclk,
   input wire logic [15:0] capTarget,
   input wire logic [15:0] voltTarget,
   input wire logic signed [15:0] stepCur,
   input wire logic stepReq,
   output logic [15:0] remainingCap,
   output logic [15:0] cellVoltage,
   output logic signed [15:0] senseCurrent,
   output logic senseValid
);
   // one register stage, like a real converter, so inputs never move on the sample edge
   always_ff @(posedge mclk)
   begin
      remainingCap <= capTarget;
      cellVoltage <= voltTarget;
      senseCurrent <= stepReq ? stepCur : ~stepCur; // stale sample is not shown
      senseValid <= stepReq;
   end
endmodule
`default_nettype wire

// file: battery_alarm_flag_logic_tb.sv
/*
 Self-checking bench for the battery alarm flag block.
 Assumes one mclk domain, APB with pready, and the measurement model.
*/
`timescale 1ns/10ps
`default_nettype none
module battery_alarm_flag_logic_tb;
   import battery_alarm_pkg::*;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic stepReq = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [15:0] capTarget = 16'h0400;
   logic [15:0] voltTarget = 16'h0F00;
   logic signed [15:0] stepCur = 16'sh0000;
   logic [7:0] socIn = 8'h00;
   logic [31:0] prdata, rd;
   logic [15:0] remainingCap, cellVoltage;
   logic signed [15:0] senseCurrent;
   logic [7:0] socOut;
   logic pready, pslverr, senseValid, battery_low_pin, socIntPulse, load_model_bit, irq, er;
   int err_total = 0;
   int tests_run = 0;
   // free-running clock, 8 ns period
   always #4 mclk = ~mclk;
   battery_alarm_flag_logic battery_alarm_flag_logic_i (.mclk(mclk), .rst_n(rst_n),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .remainingCap(remainingCap),
      .cellVoltage(cellVoltage), .socIn(socIn), .senseCurrent(senseCurrent),
      .senseValid(senseValid), .battery_low_pin(battery_low_pin), .socIntPulse(socIntPulse),
      .load_model_bit(load_model_bit), .socOut(socOut), .irq(irq));
   meas_model meas_model_i (.mclk(mclk), .capTarget(capTarget), .voltTarget(voltTarget),
      .stepCur(stepCur), .stepReq(stepReq), .remainingCap(remainingCap),
      .cellVoltage(cellVoltage), .senseCurrent(senseCurrent), .senseValid(senseValid));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
         err_total++;
      end
   endtask
   // pready sampled at each rising edge; data taken and request dropped at that same edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge mclk);
         n++;
      end
      while (pready !== 1'b1 && n < 100);
      if (pready !== 1'b1)
         err_total++;
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0000_0000);
      chk(rd, exp);
   endtask
   task automatic tick(input int k);
      repeat (k) @(negedge mclk);
   endtask
   task automatic setv(input logic [15:0] v);
      @(posedge mclk);
      voltTarget <= v;
   endtask
   task automatic setc(input logic [15:0] c);
      @(posedge mclk);
      capTarget <= c;
   endtask
   task automatic step(input logic signed [15:0] c);
      @(posedge mclk);
      stepCur <= c;
      stepReq <= 1'b1;
      @(posedge mclk);
      stepReq <= 1'b0;
   endtask
   task automatic t_reset;
      rchk(OFF_CTRL, 32'h0000_0000);
      rchk(OFF_FLAGS, 32'h0000_0000);
      chk(socIntPulse, 1'b0);
      apb(1'b0, 8'h3C, 32'h0000_0000);
      chk(er, 1'b1);
      chk(rd, 32'h0000_0000);
   endtask
   task automatic t_lowcap;
      apb(1'b1, OFF_LOWCAP_THR, 32'h0000_0064);
      setc(16'h0032);
      tick(3);
      rchk(OFF_FLAGS, 32'h0000_0001);
      chk(battery_low_pin, 1'b0);
      rchk(OFF_INT_STAT, 32'h0000_0001);
      apb(1'b1, OFF_CTRL, 32'h0000_0002);
      tick(2);
      chk(battery_low_pin, 1'b1);
      setc(16'h0064);
      tick(3);
      chk(battery_low_pin, 1'b1);
      setc(16'h0065);
      tick(3);
      chk(battery_low_pin, 1'b0);
      rchk(OFF_FLAGS, 32'h0000_0000);
      apb(1'b1, OFF_INT_CLR, 32'h0000_0007);
   endtask
   task automatic t_shut;
      apb(1'b1, OFF_SHUT_SET, 32'h0000_0BB8);
      apb(1'b1, OFF_SHUT_CLR, 32'h0000_0DAC);
      apb(1'b1, OFF_INT_EN, 32'h0000_0002);
      setv(16'h0B54);
      tick(3);
      chk(socIntPulse, 1'b1);
      tick(1);
      chk(socIntPulse, 1'b0);
      chk(irq, 1'b1);
      setv(16'h0C80);
      tick(3);
      chk(socIntPulse, 1'b0);
      rchk(OFF_FLAGS, 32'h0000_0002);
      apb(1'b1, OFF_INT_CLR, 32'h0000_0002);
      apb(1'b1, OFF_INT_EN, 32'h0000_0004);
      tick(2);
      chk(irq, 1'b0);
      setv(16'h0E10);
      tick(3);
      chk(socIntPulse, 1'b1);
      tick(1);
      chk(socIntPulse, 1'b0);
      rchk(OFF_FLAGS, 32'h0000_0000);
      chk(irq, 1'b1);
      apb(1'b1, OFF_INT_EN, 32'h0000_0000);
      tick(2);
      chk(irq, 1'b0);
      apb(1'b1, OFF_INT_CLR, 32'h0000_0004);
      rchk(OFF_INT_STAT, 32'h0000_0000);
   endtask
   // boundary: equal to the final voltage counts as discharged
   task automatic t_final;
      @(posedge mclk);
      socIn <= 8'h37;
      apb(1'b1, OFF_FINAL_V, 32'h0000_0AF0);
      setv(16'h0AF0);
      tick(3);
      chk(socOut, 8'h00);
      rchk(OFF_SOC, 32'h0000_0000);
      setv(16'h0AF1);
      tick(3);
      chk(socOut, 8'h37);
   endtask
   task automatic t_model;
      apb(1'b1, OFF_CTRL, 32'h0000_0001);
      tick(2);
      chk(load_model_bit, 1'b1);
      rchk(OFF_CTRL_STAT, 32'h0000_0001);
      apb(1'b1, OFF_CTRL_STAT, 32'h0000_0000);
      rchk(OFF_CTRL_STAT, 32'h0000_0001);
      apb(1'b1, OFF_CTRL, 32'h0000_0000);
      tick(2);
      chk(load_model_bit, 1'b0);
   endtask
   task automatic t_charge;
      step(16'sh0005);
      step(-16'sh0002);
      rchk(OFF_CHARGE, 32'h0000_0003);
      apb(1'b1, OFF_CC_GAIN, 32'h4120_0000);
      rchk(OFF_CC_GAIN, 32'h4120_0000);
      apb(1'b1, OFF_CC_DELTA, 32'h3F80_0001);
      rchk(OFF_CC_DELTA, 32'h3F80_0001);
   endtask
   task automatic complete_run;
      $display("checks %0d errors %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // main sequence after ten reset cycles
   initial
   begin
      repeat (10) @(posedge mclk);
      rst_n <= 1'b1;
      t_reset;
      t_lowcap;
      t_shut;
      t_final;
      t_model;
      t_charge;
      complete_run;
   end
   // watchdog, far beyond the few hundred cycles the run needs
   initial
   begin
      #200000;
      err_total++;
      complete_run;
   end
endmodule
`default_nettype wire
